// *** rtl/acs_pkg.sv ***
// shared constants and carriers for the converter control sequencer
package acs_pkg;
	// register block
	localparam logic [31:0] ACS_BASE = 32'h4004_c000;
	localparam logic [5:0] OFS_CS = 6'h00;
	localparam logic [5:0] OFS_RESULT = 6'h04;
	localparam logic [5:0] OFS_QCS = 6'h08;
	localparam logic [5:0] OFS_QPORT = 6'h0c;
	localparam logic [5:0] OFS_DIV = 6'h10;
	localparam logic [5:0] OFS_IRQ_RAW = 6'h14;
	localparam logic [5:0] OFS_IRQ_EN = 6'h18;
	localparam logic [5:0] OFS_IRQ_FORCE = 6'h1c;
	localparam logic [5:0] OFS_IRQ_STAT = 6'h20;
	// control, status and divider field positions
	localparam int CS_EN = 0;
	localparam int CS_BIAS = 1;
	localparam int CS_ONCE = 2;
	localparam int CS_MANY = 3;
	localparam int CS_READY = 8;
	localparam int CS_ERR = 9;
	localparam int CS_STICKY = 10;
	localparam int CS_SEL_LSB = 12;
	localparam int CS_RR_LSB = 16;
	localparam int DIV_FRAC_LSB = 0;
	localparam int DIV_INT_LSB = 8;
	// reset values
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam logic [4:0] RR_RESET = 5'h00;
	localparam logic [15:0] INT_RESET = 16'h0000;
	localparam logic [7:0] FRAC_RESET = 8'h00;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	// channels and timing
	localparam logic [2:0] TEMP_CH = 3'h4;
	localparam int CLK_HZ = 20_000_000;
	localparam int CONV_CYCLES = 96;
	localparam logic [6:0] CONV_LAST = 7'(CONV_CYCLES - 1);
	// converter core controls
	typedef struct packed {
		logic power;
		logic clk_en;
		logic bias;
		logic [3:0] ext_sel;
		logic temp_sel;
		logic start;
	} acs_analog_t;
	// completion strobe for sample storage
	typedef struct packed {
		logic valid;
		logic err;
		logic [11:0] result;
	} acs_done_t;
endpackage

// *** rtl/acs_top.sv ***
// converter control sequencer with its ahb-lite register slave
`timescale 1ns/10ps
module acs_top
	import acs_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [11:0] core_result,
	input wire logic core_error,
	input wire logic queue_irq_raw,
	output acs_analog_t analog,
	output acs_done_t done
);
	logic ctl_en;
	logic ctl_bias;
	logic ctl_many;
	logic once_pend;
	logic [4:0] rr_mask;
	logic [2:0] chan;
	logic err_last;
	logic err_sticky;
	logic [11:0] result;
	logic [15:0] div_int;
	logic [7:0] div_frac;
	logic int_enable;
	logic int_force;
	logic busy;
	logic [6:0] conv_cnt;
	logic [16:0] pace_cnt;
	logic [7:0] pace_acc;
	logic wr_act;
	logic [5:0] wr_ofs;
	logic rd_pend;
	logic [5:0] rd_ofs;
	logic hit;
	logic wr_cs;
	logic wr_div;
	logic pace_on;
	logic pace_trig;
	logic launch;
	logic done_now;
	logic [8:0] next_acc;
	logic [2:0] next_chan;
	logic [31:0] rd_value;

	// next enabled channel after the current one, wrapping
	function automatic logic [2:0] acs_next_ch(input logic [2:0] cur,
		input logic [4:0] mask);
		logic [2:0] c;
		logic [2:0] res;
		logic found;
		c = cur;
		res = cur;
		found = 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			c = (c >= TEMP_CH) ? 3'h0 : c + 3'h1;
			if (!found && mask[c])
			begin
				res = c;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////
	// bus decode
	// base match
	assign hit = hsel && htrans[1] && hready
		&& (haddr[31:6] == ACS_BASE[31:6]);
	assign wr_cs = wr_act && (wr_ofs == OFS_CS);
	assign wr_div = wr_act && (wr_ofs == OFS_DIV);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_act <= 1'b0;
			wr_ofs <= 6'h00;
		end
		else
		begin
			wr_act <= hit && hwrite;
			wr_ofs <= haddr[5:0];
		end
	end

	// reads take one wait state so a write just before is visible
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_pend <= 1'b0;
			rd_ofs <= 6'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end
		else
		begin
			rd_pend <= hit && !hwrite;
			hreadyout <= !(hit && !hwrite);
			if (hit && !hwrite)
				rd_ofs <= haddr[5:0];
			if (rd_pend)
				hrdata <= rd_value;
		end
	end

	always_comb
	begin
		rd_value = 32'h0000_0000;
		case (rd_ofs)
			OFS_CS:
			begin
				rd_value[CS_EN] = ctl_en;
				rd_value[CS_BIAS] = ctl_bias;
				rd_value[CS_MANY] = ctl_many;
				rd_value[CS_READY] = ctl_en && !busy;
				rd_value[CS_ERR] = err_last;
				rd_value[CS_STICKY] = err_sticky;
				rd_value[CS_SEL_LSB +: 3] = chan;
				rd_value[CS_RR_LSB +: 5] = rr_mask;
			end
			OFS_RESULT: rd_value[11:0] = result;
			OFS_DIV:
			begin
				rd_value[DIV_INT_LSB +: 16] = div_int;
				rd_value[DIV_FRAC_LSB +: 8] = div_frac;
			end
			OFS_IRQ_RAW: rd_value[0] = queue_irq_raw;
			OFS_IRQ_EN: rd_value[0] = int_enable;
			OFS_IRQ_FORCE: rd_value[0] = int_force;
			OFS_IRQ_STAT: rd_value[0] = (queue_irq_raw && int_enable)
				|| int_force;
			default: rd_value = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// control register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctl_en <= 1'b0;
			ctl_bias <= 1'b0;
			ctl_many <= 1'b0;
			rr_mask <= RR_RESET;
		end
		else if (wr_cs)
		begin
			ctl_en <= hwdata[CS_EN];
			ctl_bias <= hwdata[CS_BIAS];
			ctl_many <= hwdata[CS_MANY];
			rr_mask <= hwdata[CS_RR_LSB +: 5];
		end
	end

	// one-shot request, dropped in free-running mode
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			once_pend <= 1'b0;
		else if (wr_cs && hwdata[CS_ONCE] && !hwdata[CS_MANY]
			&& hwdata[CS_EN])
			once_pend <= 1'b1;
		else if (launch || ctl_many || !ctl_en)
			once_pend <= 1'b0;
	end

	assign next_chan = (done_now && (rr_mask != 5'h00))
		? acs_next_ch(chan, rr_mask)
		: (wr_cs ? hwdata[CS_SEL_LSB +: 3] : chan);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			chan <= SEL_RESET;
		else
			chan <= next_chan;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			int_enable <= 1'b0;
			int_force <= 1'b0;
		end
		else if (wr_act && (wr_ofs == OFS_IRQ_EN))
			int_enable <= hwdata[0];
		else if (wr_act && (wr_ofs == OFS_IRQ_FORCE))
			int_force <= hwdata[0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_int <= INT_RESET;
			div_frac <= FRAC_RESET;
		end
		else if (wr_div)
		begin
			div_int <= hwdata[DIV_INT_LSB +: 16];
			div_frac <= hwdata[DIV_FRAC_LSB +: 8];
		end
	end

	////////////////////////////////////////////////////////////////
	// pacing timer
	assign pace_on = (div_int != INT_RESET) || (div_frac != FRAC_RESET);
	assign pace_trig = !pace_on || (pace_cnt == 17'h0_0000);
	assign next_acc = {1'b0, pace_acc} + {1'b0, div_frac};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pace_cnt <= 17'h0_0000;
			pace_acc <= 8'h00;
		end
		else if (wr_div)
		begin
			pace_cnt <= {1'b0, hwdata[DIV_INT_LSB +: 16]};
			pace_acc <= 8'h00;
		end
		else if (!(ctl_en && ctl_many))
		begin
			pace_cnt <= {1'b0, div_int};
			pace_acc <= 8'h00;
		end
		else if (pace_cnt == 17'h0_0000)
		begin
			pace_acc <= next_acc[7:0];
			pace_cnt <= {1'b0, div_int} + {16'h0000, next_acc[8]};
		end
		else
			pace_cnt <= pace_cnt - 17'h0_0001;
	end

	////////////////////////////////////////////////////////////////
	// conversion sequencing
	// disabled converter starts nothing
	// free-running starts
	// a finishing conversion frees the core for an immediate restart
	assign launch = ctl_en && (!busy || done_now)
		&& (ctl_many ? pace_trig : once_pend);
	assign done_now = busy && (conv_cnt == 7'h00);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			busy <= 1'b0;
			conv_cnt <= 7'h00;
		end
		else if (!ctl_en)
			busy <= 1'b0;
		else if (launch)
		begin
			busy <= 1'b1;
			conv_cnt <= CONV_LAST;
		end
		else if (done_now)
			busy <= 1'b0;
		else if (busy)
			conv_cnt <= conv_cnt - 7'h01;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			result <= RESULT_RESET;
			err_last <= 1'b0;
		end
		else if (done_now)
		begin
			result <= core_result;
			err_last <= core_error;
		end
	end

	// sticky error, set wins over clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			err_sticky <= 1'b0;
		else if (done_now && core_error)
			err_sticky <= 1'b1;
		else if (wr_cs && hwdata[CS_STICKY])
			err_sticky <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// outputs to core and sample storage
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			analog <= '0;
		else
		begin
			analog.power <= ctl_en;
			analog.clk_en <= ctl_en;
			analog.bias <= ctl_bias;
			// external mux
			// mux tracks the channel without lag, so a restart
			// at the end of a conversion uses the advanced channel
			for (int i = 0; i < 4; i++)
				analog.ext_sel[i] <= (next_chan == 3'(i));
			analog.temp_sel <= (next_chan == TEMP_CH);
			analog.start <= launch;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			done <= '0;
		else
		begin
			done.valid <= done_now;
			if (done_now)
			begin
				done.err <= core_error;
				done.result <= core_result;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	conv_length_a: assert property (@(posedge hclk)
		disable iff (!hresetn || !ctl_en) launch |-> ##96 done_now)
		else $error("conversion length wrong");
	busy_no_start_a: assert property (@(posedge hclk)
		disable iff (!hresetn) busy && !done_now |-> !launch)
		else $error("start while busy");
	off_no_start_a: assert property (@(posedge hclk)
		disable iff (!hresetn) !ctl_en |-> !launch ##1 !busy)
		else $error("start while disabled");
	once_dropped_a: assert property (@(posedge hclk)
		disable iff (!hresetn) ctl_many && !wr_cs |=> !once_pend)
		else $error("one-shot kept in free-run");
	sticky_set_a: assert property (@(posedge hclk)
		disable iff (!hresetn) done_now && core_error |=> err_sticky)
		else $error("sticky error missed");
	result_load_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		done_now |=> result == $past(core_result)
			&& err_last == $past(core_error))
		else $error("result not captured");
	rr_next_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		done_now && rr_mask != 5'h00 |=> rr_mask[chan])
		else $error("round-robin skipped mask");
	pace_reload_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		ctl_en && ctl_many && !wr_div && div_frac == 8'h00
			&& pace_cnt == 17'h0_0000 |=> pace_cnt == {1'b0, div_int})
		else $error("pacing reload wrong");
	div_restart_a: assert property (@(posedge hclk)
		disable iff (!hresetn) wr_div |=> pace_acc == 8'h00
			&& pace_cnt == {1'b0, div_int})
		else $error("pacing not restarted");
	strobe_a: assert property (@(posedge hclk)
		disable iff (!hresetn) done_now |=> done.valid ##1 !done.valid)
		else $error("strobe not one cycle");

	many_run_c: cover property (@(posedge hclk) disable iff (!hresetn)
		ctl_many && launch ##[1:200] done_now && launch);
	err_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
		done_now && core_error);
	rr_step_c: cover property (@(posedge hclk) disable iff (!hresetn)
		done_now && rr_mask != 5'h00);
	once_run_c: cover property (@(posedge hclk) disable iff (!hresetn)
		!ctl_many && launch);
endmodule

// *** tb/acs_core_model.sv ***
// stand-in for the analogue core: converts for 96 clocks after each start
`timescale 1ns/10ps
module acs_core_model
	import acs_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input acs_analog_t analog,
	input wire logic [7:0] salt,
	input wire logic bad,
	output logic [11:0] core_result,
	output logic core_error
);
	int cnt;
	logic [2:0] ch;
	// routed channel, 7 when nothing is routed
	assign ch = analog.temp_sel ? 3'h4 : analog.ext_sel[3] ? 3'h3 :
		analog.ext_sel[2] ? 3'h2 : analog.ext_sel[1] ? 3'h1 :
		analog.ext_sel[0] ? 3'h0 : 3'h7;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt <= 0;
			core_result <= 12'h000;
			core_error <= 1'b0;
		end
		// only a powered, clocked core converts
		else if (analog.start && analog.power && analog.clk_en)
		begin
			cnt <= 96;
			core_result <= {1'b0, ch, salt};
			// unbiased sensor gives a failed conversion
			core_error <= bad | (ch == 3'h4 && !analog.bias);
		end
		else if (cnt != 0)
		begin
			cnt <= cnt - 1;
			// outputs stop meaning anything once the hold runs out
			if (cnt == 1)
			begin
				core_result <= ~core_result;
				core_error <= ~core_error;
			end
		end
	end
endmodule

// *** tb/adc_control_sequencer_tb.sv ***
// self-checking bench for the converter control sequencer
`timescale 1ns/10ps
module adc_control_sequencer_tb;
	import acs_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq = 0, bad = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
	logic [7:0] salt = 8'h00;
	logic hreadyout, hresp;
	logic [31:0] hrdata;
	logic [11:0] core_result;
	logic core_error;
	logic [12:0] x;
	acs_analog_t analog;
	acs_done_t done;
	int bad_count = 0, checked = 0, cyc = 0, last_st = 0, c;
	int en = 0, bias = 0, many = 0, sel = 0, mask = 0, sticky = 0, err = 0;
	logic [12:0] exp_q[$];
	int st_q[$];
	logic [5:0] ofs[10] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14,
		6'h18, 6'h1c, 6'h20, 6'h24};
	int divs[3] = '{0, 119 << 8, (119 << 8) | 128};
	int span[3] = '{384, 480, 482};

	acs_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .core_result(core_result), .core_error(core_error),
		.queue_irq_raw(irq), .analog(analog), .done(done));
	acs_core_model core (.hclk(hclk), .hresetn(hresetn), .analog(analog),
		.salt(salt), .bad(bad), .core_result(core_result),
		.core_error(core_error));

	initial
	begin
		forever #25 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_gap(input int got, input int exp);
		checked++;
		if (got != exp)
		begin
			bad_count++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= ACS_BASE | 32'(a);
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		cmp(32'(hresp), 32'h0000_0000);
	endtask

	task automatic rchk(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		cmp(rd, e);
	endtask

	task automatic wcs(input logic [31:0] d);
		en = d[0];
		bias = d[1];
		many = d[3];
		sel = d[14:12];
		mask = d[20:16];
		if (d[10])
			sticky = 0;
		bus(1'b1, OFS_CS, d);
	endtask

	task automatic idle;
		for (int k = 0; k < 300 && exp_q.size() != 0; k++)
			@(posedge hclk);
	endtask

	function automatic logic [31:0] cs_exp(input int rdy);
		return 32'((mask << 16) | (sel << 12) | (sticky << 10) | (err << 9)
			| (rdy << 8) | (many << 3) | (bias << 1) | en);
	endfunction

	function automatic int nxt(input int s);
		for (int i = 1; i <= 5; i++)
			if (mask[(s + i) % 5])
				return (s + i) % 5;
		return s;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reference model: expected sample at each start, checked at each strobe
	always @(posedge hclk)
	begin
		cyc++;
		// a strobe is scored before a start seen at the same edge, so a
		// back-to-back start takes the advanced channel
		if (done.valid === 1'b1)
		begin
			cmp_gap(cyc - last_st, 96);
			x = exp_q.pop_front();
			cmp({19'h0, done.err, done.result}, {19'h0, x});
			err = x[12];
			sticky = sticky | err;
			if (mask != 0)
				sel = nxt(sel);
		end
		if (analog.start === 1'b1)
		begin
			exp_q.push_back({bad | (sel == 4 && bias == 0), 1'b0,
				3'(sel), salt});
			st_q.push_back(cyc);
			last_st = cyc;
			salt <= 8'($urandom);
		end
		if (cyc > 20000)
		begin
			bad_count++;
			end_of_test;
		end
	end

	initial
	begin
		void'($urandom(31));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b1, 6'h24, 32'hffff_ffff);
		bus(1'b1, OFS_RESULT, 32'hffff_ffff);
		foreach (ofs[i])
			rchk(ofs[i], 32'h0000_0000);
		wcs(32'h0000_0004);
		repeat (150) @(posedge hclk);
		cmp_gap(st_q.size(), 0);
		rchk(OFS_CS, cs_exp(0));
		for (int k = 0; k < 6; k++)
		begin
			bad <= (k == 1);
			c = $urandom % 5;
			// bias is on before any temperature sample
			wcs(32'h0000_0007 | 32'(c << 12));
			repeat (5) @(posedge hclk);
			rchk(OFS_CS, cs_exp(0));
			idle;
			rchk(OFS_CS, cs_exp(1));
			rchk(OFS_RESULT, {20'h0, x[11:0]});
		end
		wcs(32'h0000_0401);
		rchk(OFS_CS, cs_exp(1));
		for (int t = 0; t < 3; t++)
		begin
			bus(1'b1, OFS_DIV, 32'(divs[t]));
			rchk(OFS_DIV, 32'(divs[t]));
			st_q.delete();
			wcs(32'h0006_0009);
			for (int k = 0; k < 1000 && st_q.size() < 5; k++)
				@(posedge hclk);
			cmp_gap(st_q[4] - st_q[0], span[t]);
			c = 0;
			do @(posedge hclk); while (done.valid !== 1'b1 && ++c < 300);
			// let the model advance its channel before it is written back
			@(posedge hclk);
			wcs(32'h0000_0001 | 32'(sel << 12));
			idle;
			rchk(OFS_CS, cs_exp(1));
		end
		for (int i = 0; i < 8; i++)
		begin
			irq <= i[0];
			bus(1'b1, OFS_IRQ_EN, 32'(i[1]));
			bus(1'b1, OFS_IRQ_FORCE, 32'(i[2]));
			rchk(OFS_IRQ_RAW, 32'(i[0]));
			rchk(OFS_IRQ_STAT, 32'((i[0] & i[1]) | i[2]));
		end
		end_of_test;
	end
endmodule
